// ### src/rcw_pkg.sv
// constants and carrier types of the runaway code watchdog
package rcw_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [15:0] RCW_CLR_PORT_ADDR = 16'hFFFF;
	localparam logic [15:0] RCW_CFG_ADDR      = 16'h001F;
	localparam logic [15:0] RCW_CAUSE_ADDR    = 16'h0001;

	// configuration register fields
	localparam int          RCW_CFG_DIS_BIT    = 0;
	localparam int          RCW_CFG_RATE_BIT   = 1;
	localparam int          RCW_CFG_STOPEN_BIT = 2;
	localparam logic [7:0]  RCW_CFG_RESET      = 8'h00;

	// reset cause register fields
	localparam int          RCW_CAUSE_WDG_BIT   = 0;
	localparam int          RCW_CAUSE_ILL_BIT   = 1;
	localparam int          RCW_CAUSE_OFF_BIT   = 2;
	localparam int          RCW_CAUSE_PULSE_BIT = 3;
	localparam logic [1:0]  RCW_CAUSE_RESET     = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// counter chain
	localparam int          RCW_PRE_W       = 12;
	localparam int          RCW_CNT_W       = 6;
	localparam int          RCW_LONG_TAP    = 12;
	localparam int          RCW_SHORT_TAP   = 7;
	localparam int          RCW_CLR_LO_BIT  = 4;
	localparam logic [17:0] RCW_LONG_LIMIT  = 18'h3FFF0;
	localparam logic [17:0] RCW_SHORT_LIMIT = 18'h01FF0;

	// counts of oscillator cycles
	localparam int          RCW_POR_CLEAR_CYCLES = 4096;
	localparam int          RCW_RST_PULSE_CYCLES = 32;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} rcw_bus_req_t;

	typedef struct packed {
		logic stop_exec;
		logic stop_mode;
		logic vector_fetch;
		logic int_reset;
		logic monitor_entry;
		logic monitor_mode;
		logic break_active;
	} rcw_mode_t;

	typedef struct packed {
		logic irq_vtst;
		logic rst_vtst;
	} rcw_pins_t;

endpackage

// ### src/rcw_prescaler.sv
// oscillator prescaler with whole and upper-stage clears
`timescale 1ns/10ps
module rcw_prescaler #(
	parameter int W     = 12,
	parameter int CLR_LO = 4
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// control
	input  wire logic         tick,
	input  wire logic         clr_all,
	input  wire logic         clr_hi,
	// state
	output logic [W-1:0]      q
);

	localparam logic [W-1:0] HI_MASK = {W{1'b1}} << CLR_LO;

	initial begin
		if (W < 2 || CLR_LO < 1 || CLR_LO >= W) begin
			$error("rcw_prescaler: bad width or clear boundary");
		end
	end

	logic [W-1:0] nxt_q;

	always_comb begin
		nxt_q = q + {{(W-1){1'b0}}, tick};
		if (clr_hi) begin
			nxt_q = nxt_q & ~HI_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || clr_all) begin
			q <= '0;
		end else begin
			q <= nxt_q;
		end
	end

endmodule // rcw_prescaler

// ### src/rcw_top.sv
// runaway code watchdog: prescaler, counter, reset pulse and registers
//
// Summary of operation
// - 6-bit counter fed by 12-bit oscillator prescaler
// - overflow raises system reset, two timeouts
// - any write to FFFF clears counter, upper prescaler stages
// - reset drives pin low 32 cycles, flags cause
// - read of FFFF returns vector low byte
// - stop instruction clears whole prescaler
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - disable and rate follow configuration bits live
// - disable bit one means no watchdog reset
// - rate bit one picks shorter timeout
// - test-voltage monitor entry disables while voltage stays
// - blank-vector monitor entry disables until power-on
// - break with test voltage on reset disables
// - counting continues in wait mode
// - stop mode gates clock, clears prescaler
// - disallowed stop instruction gives illegal opcode reset
// - never raises a cpu interrupt request
`timescale 1ns/10ps
module rcw_top #(
	parameter int OSC_DIV = 1
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// register port
	input  rcw_pkg::rcw_bus_req_t   bus_req,
	input  wire logic [7:0]         reset_vector_lo,
	output logic [7:0]              rd_data_ff,
	// cpu modes and events
	input  rcw_pkg::rcw_mode_t      mode,
	// pins seen at test voltage
	input  rcw_pkg::rcw_pins_t      vtst_pins,
	// resets out
	output logic                    sys_reset_ff,
	output logic                    illegal_reset_ff,
	output logic                    rst_pin_o_n_ff,
	output logic                    rst_pin_oe_ff,
	// live configuration
	output logic                    watchdog_disable_cfg_ff,
	output logic                    watchdog_rate_select_ff
);
	import rcw_pkg::*;

	initial begin
		if (OSC_DIV < 1 || OSC_DIV > 65535) begin
			$error("rcw_top: OSC_DIV out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator rate as an enable
	logic [15:0] osc_div_ff;
	logic        osc_tick_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			osc_div_ff  <= 16'h0000;
			osc_tick_ff <= 1'b0;
		end else if (osc_div_ff == 16'(OSC_DIV - 1)) begin
			osc_div_ff  <= 16'h0000;
			osc_tick_ff <= 1'b1;
		end else begin
			osc_div_ff  <= osc_div_ff + 16'h0001;
			osc_tick_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] irq_sync_ff;
	logic [1:0] rstp_sync_ff;
	logic       irq_vtst;
	logic       rstp_vtst;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_sync_ff  <= 2'h0;
			rstp_sync_ff <= 2'h0;
		end else begin
			irq_sync_ff  <= {irq_sync_ff[0], vtst_pins.irq_vtst};
			rstp_sync_ff <= {rstp_sync_ff[0], vtst_pins.rst_vtst};
		end
	end

	assign irq_vtst  = irq_sync_ff[1];
	assign rstp_vtst = rstp_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// register decode
	logic clr_port_wr;
	logic clr_port_rd;
	logic cfg_wr;
	logic cause_rd;

	assign clr_port_wr = bus_req.wr && bus_req.addr == RCW_CLR_PORT_ADDR;
	assign clr_port_rd = bus_req.rd && bus_req.addr == RCW_CLR_PORT_ADDR;
	assign cfg_wr      = bus_req.wr && bus_req.addr == RCW_CFG_ADDR;
	assign cause_rd    = bus_req.rd && bus_req.addr == RCW_CAUSE_ADDR;

	////////////////////////////////////////////////////////////////////////
	// write-once configuration
	logic [7:0] cfg_ff;
	logic       cfg_locked_ff;
	logic       pulse_active_ff;
	logic       internal_rst;

	// any reset re-opens the one write
	assign internal_rst = mode.int_reset || pulse_active_ff || illegal_reset_ff;

	always_ff @(posedge sys_clk) begin
		if (rst || internal_rst) begin
			cfg_ff        <= RCW_CFG_RESET;
			cfg_locked_ff <= 1'b0;
		end else if (cfg_wr && !cfg_locked_ff) begin
			cfg_ff        <= bus_req.wdata;
			cfg_locked_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			watchdog_disable_cfg_ff <= 1'b0;
			watchdog_rate_select_ff <= 1'b0;
		end else begin
			watchdog_disable_cfg_ff <= cfg_ff[RCW_CFG_DIS_BIT];
			watchdog_rate_select_ff <= cfg_ff[RCW_CFG_RATE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// monitor and break disables
	logic mon_vtst_entry_ff;
	logic blank_mon_off_ff;
	logic wdg_off;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mon_vtst_entry_ff <= 1'b0;
		end else if (mode.monitor_entry) begin
			mon_vtst_entry_ff <= irq_vtst;
		end
	end

	// only power-on reset releases this one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			blank_mon_off_ff <= 1'b0;
		end else if (mode.monitor_entry && !irq_vtst) begin
			blank_mon_off_ff <= 1'b1;
		end
	end

	assign wdg_off = watchdog_disable_cfg_ff
		|| (mode.monitor_mode && mon_vtst_entry_ff && (irq_vtst || rstp_vtst))
		|| blank_mon_off_ff
		|| (mode.break_active && rstp_vtst);

	////////////////////////////////////////////////////////////////////////
	// power-on prescaler clear
	logic [12:0] por_cnt_ff;
	logic        por_clear_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			por_cnt_ff   <= 13'h0000;
			por_clear_ff <= 1'b0;
		end else begin
			por_clear_ff <= 1'b0;
			if (osc_tick_ff && por_cnt_ff != 13'(RCW_POR_CLEAR_CYCLES)) begin
				por_cnt_ff <= por_cnt_ff + 13'h0001;
				if (por_cnt_ff == 13'(RCW_POR_CLEAR_CYCLES - 1)) begin
					por_clear_ff <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler and counter
	logic                 stop_ok;
	logic                 cnt_tick;
	logic                 pre_clr_all;
	logic [RCW_PRE_W-1:0] pre_q;
	logic [RCW_CNT_W-1:0] cnt_ff;
	logic                 tap_carry;
	logic [17:0]          elapsed;
	logic [17:0]          limit_m1;
	logic                 timeout;

	assign stop_ok  = cfg_ff[RCW_CFG_STOPEN_BIT];
	// wait mode does not gate the clock, only stop does
	assign cnt_tick = osc_tick_ff && !mode.stop_mode;

	assign pre_clr_all = internal_rst
		|| (mode.stop_exec && stop_ok)
		|| mode.stop_mode
		|| por_clear_ff
		|| mode.vector_fetch
		|| wdg_off;

	rcw_prescaler #(
		.W      (RCW_PRE_W),
		.CLR_LO (RCW_CLR_LO_BIT)
	) u_pre (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (cnt_tick),
		.clr_all (pre_clr_all),
		.clr_hi  (clr_port_wr),
		.q       (pre_q)
	);

	// carry out of the tap selected by the rate bit
	assign tap_carry = cnt_tick && (watchdog_rate_select_ff
		? &pre_q[RCW_SHORT_TAP-1:0] : &pre_q[RCW_LONG_TAP-1:0]);

	assign elapsed  = watchdog_rate_select_ff
		? {5'h00, cnt_ff, pre_q[RCW_SHORT_TAP-1:0]} : {cnt_ff, pre_q};
	assign limit_m1 = (watchdog_rate_select_ff ? RCW_SHORT_LIMIT : RCW_LONG_LIMIT) - 18'h00001;
	assign timeout  = cnt_tick && !wdg_off && !pulse_active_ff && elapsed == limit_m1;

	always_ff @(posedge sys_clk) begin
		if (rst || internal_rst || clr_port_wr || wdg_off) begin
			cnt_ff <= '0;
		end else if (tap_carry) begin
			cnt_ff <= cnt_ff + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset pulse on the pin
	logic [5:0] pulse_cnt_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pulse_active_ff <= 1'b0;
			pulse_cnt_ff    <= 6'h00;
			rst_pin_o_n_ff  <= 1'b1;
			rst_pin_oe_ff   <= 1'b0;
			sys_reset_ff    <= 1'b0;
		end else if (timeout) begin
			pulse_active_ff <= 1'b1;
			pulse_cnt_ff    <= 6'h00;
			rst_pin_o_n_ff  <= 1'b0;
			rst_pin_oe_ff   <= 1'b1;
			sys_reset_ff    <= 1'b1;
		end else if (pulse_active_ff && osc_tick_ff) begin
			if (pulse_cnt_ff == 6'(RCW_RST_PULSE_CYCLES - 1)) begin
				pulse_active_ff <= 1'b0;
				rst_pin_o_n_ff  <= 1'b1;
				rst_pin_oe_ff   <= 1'b0;
				sys_reset_ff    <= 1'b0;
			end
			pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// illegal stop instruction
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			illegal_reset_ff <= 1'b0;
		end else begin
			illegal_reset_ff <= mode.stop_exec && !stop_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset cause register, set beats read-clear
	logic [1:0] cause_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cause_ff <= RCW_CAUSE_RESET;
		end else begin
			cause_ff[RCW_CAUSE_WDG_BIT] <= timeout
				|| (cause_ff[RCW_CAUSE_WDG_BIT] && !cause_rd);
			cause_ff[RCW_CAUSE_ILL_BIT] <= (mode.stop_exec && !stop_ok)
				|| (cause_ff[RCW_CAUSE_ILL_BIT] && !cause_rd);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
		end else if (clr_port_rd) begin
			rd_data_ff <= reset_vector_lo;
		end else if (cause_rd) begin
			rd_data_ff <= {4'h0, pulse_active_ff, wdg_off, cause_ff};
		end else if (bus_req.rd && bus_req.addr == RCW_CFG_ADDR) begin
			rd_data_ff <= cfg_ff;
		end else begin
			rd_data_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_pulse_bound: assert property (
		pulse_active_ff |-> pulse_cnt_ff < 6'(RCW_RST_PULSE_CYCLES))
		else $error("reset pulse counter overran");

	chk_pulse_length: assert property (
		$fell(pulse_active_ff) |-> $past(pulse_cnt_ff) == 6'(RCW_RST_PULSE_CYCLES - 1))
		else $error("reset pulse ended at wrong length");

	chk_pin_follows: assert property (
		rst_pin_oe_ff == pulse_active_ff && rst_pin_o_n_ff == !pulse_active_ff)
		else $error("reset pin does not follow pulse");

	chk_cause_flag: assert property (
		$rose(pulse_active_ff) |-> cause_ff[RCW_CAUSE_WDG_BIT])
		else $error("watchdog cause not flagged");

	chk_service_clear: assert property (
		clr_port_wr |=> cnt_ff == '0 && pre_q[RCW_PRE_W-1:RCW_CLR_LO_BIT] == '0)
		else $error("service write did not clear chain");

	chk_off_hold: assert property (
		wdg_off |=> cnt_ff == '0 && pre_q == '0)
		else $error("disabled watchdog not held clear");

	chk_off_no_reset: assert property (
		wdg_off && !pulse_active_ff |=> !pulse_active_ff)
		else $error("disabled watchdog raised reset");

	chk_read_vector: assert property (
		clr_port_rd |=> rd_data_ff == $past(reset_vector_lo) && ($past(internal_rst || wdg_off || clr_port_wr)
			|| cnt_ff == $past(cnt_ff) + {5'h00, $past(tap_carry)}))
		else $error("vector read wrong or disturbed counter");

	chk_stop_clear: assert property (
		mode.stop_mode |=> pre_q == '0)
		else $error("prescaler counted in stop mode");

	chk_fetch_clear: assert property (
		mode.vector_fetch |=> pre_q == '0)
		else $error("vector fetch did not clear prescaler");

	chk_illegal_stop: assert property (
		mode.stop_exec && !stop_ok |=> illegal_reset_ff && cause_ff[RCW_CAUSE_ILL_BIT])
		else $error("disallowed stop gave no illegal reset");

	chk_cnt_step: assert property (
		$changed(cnt_ff) |-> cnt_ff == '0 || cnt_ff == $past(cnt_ff) + 6'h01)
		else $error("counter moved by other than one");

	chk_blank_latch: assert property (
		blank_mon_off_ff |=> blank_mon_off_ff)
		else $error("blank-vector disable released early");

endmodule // rcw_top

// ### testbench/testbench.sv
// self-checking bench of the runaway code watchdog
`timescale 1ns/10ps
module testbench;
	import rcw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	rcw_bus_req_t bus_req = '0;
	logic [7:0]   reset_vector_lo = 8'h00;
	logic [7:0]   rd_data_ff;
	rcw_mode_t    mode = '0;
	rcw_pins_t    vtst_pins = '0;
	logic         sys_reset_ff;
	logic         illegal_reset_ff;
	logic         rst_pin_o_n_ff;
	logic         rst_pin_oe_ff;
	logic         dis_q;
	logic         rate_q;
	logic         rd_dly = 1'b0;
	logic [7:0]   exp_q[$];
	logic [7:0]   rnd = 8'h34;
	int           n_fail = 0;
	int           check_count = 0;

	always #20 sys_clk = ~sys_clk;

	rcw_top #(.OSC_DIV(1)) u_dut (
		.sys_clk                 (sys_clk),
		.rst                     (rst),
		.bus_req                 (bus_req),
		.reset_vector_lo         (reset_vector_lo),
		.rd_data_ff              (rd_data_ff),
		.mode                    (mode),
		.vtst_pins               (vtst_pins),
		.sys_reset_ff            (sys_reset_ff),
		.illegal_reset_ff        (illegal_reset_ff),
		.rst_pin_o_n_ff          (rst_pin_o_n_ff),
		.rst_pin_oe_ff           (rst_pin_oe_ff),
		.watchdog_disable_cfg_ff (dis_q),
		.watchdog_rate_select_ff (rate_q)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done();
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// read results land one cycle after the strobe
	always @(posedge sys_clk) rd_dly <= bus_req.rd;
	always @(negedge sys_clk) begin
		if (rd_dly) begin
			chk("rd_data", {10'h000, exp_q.pop_front()}, {10'h000, rd_data_ff});
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		exp_q.push_back(e);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
	endtask

	task automatic quiet(input int c);
		int bad;
		bad = 0;
		repeat (c) begin
			@(negedge sys_clk);
			if (sys_reset_ff !== 1'b0) bad++;
		end
		chk("no_reset", 18'h0, bad[17:0]);
		@(posedge sys_clk);
	endtask

	// timeout from the last clear, then pulse shape and cause
	task automatic timeout_chk();
		int n;
		int oe;
		int lo;
		n = 0;
		oe = 0;
		lo = 0;
		while (sys_reset_ff !== 1'b1 && n < 9000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("timeout", 18'h1, {17'h0, n >= 8150 && n <= 8190});
		while (rst_pin_oe_ff === 1'b1 && oe < 100) begin
			if (rst_pin_o_n_ff === 1'b0) lo++;
			oe++;
			@(negedge sys_clk);
		end
		chk("pulse_oe", 18'd32, oe[17:0]);
		chk("pulse_low", 18'd32, lo[17:0]);
		rd(RCW_CAUSE_ADDR, 8'h01);
		rd(RCW_CAUSE_ADDR, 8'h00);
	endtask

	task automatic mode_pulse(input int which);
		@(posedge sys_clk);
		case (which)
			0: mode.stop_exec <= 1'b1;
			1: mode.int_reset <= 1'b1;
			2: mode.monitor_entry <= 1'b1;
			default: mode.vector_fetch <= 1'b1;
		endcase
		@(posedge sys_clk);
		mode.stop_exec <= 1'b0;
		mode.int_reset <= 1'b0;
		mode.monitor_entry <= 1'b0;
		mode.vector_fetch <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk("pin_oe", 18'h0, {17'h0, rst_pin_oe_ff});
		chk("pin_o_n", 18'h1, {17'h0, rst_pin_o_n_ff});
		chk("cfg", 18'h0, {16'h0, dis_q, rate_q});
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			reset_vector_lo <= rnd;
			rd(RCW_CLR_PORT_ADDR, rnd);
		end
		rd(16'h1234, 8'h00);
		wr(RCW_CFG_ADDR, 8'h02);
		wr(RCW_CFG_ADDR, 8'h01);
		wr(RCW_CLR_PORT_ADDR, rnd);
		rd(RCW_CFG_ADDR, 8'h02);
		@(negedge sys_clk);
		chk("rate", 18'h1, {17'h0, rate_q});
		chk("dis", 18'h0, {17'h0, dis_q});
		// service keeps it quiet past the short timeout
		for (int i = 0; i < 3; i++) begin
			quiet(8000);
			rnd = lfsr(rnd);
			wr(RCW_CLR_PORT_ADDR, rnd);
		end
		reset_vector_lo <= rnd;
		rd(RCW_CLR_PORT_ADDR, rnd);
		timeout_chk();
		chk("cfg_after", 18'h0, {16'h0, dis_q, rate_q});
		// stop barred by configuration
		wr(RCW_CFG_ADDR, 8'h02);
		mode_pulse(0);
		@(negedge sys_clk);
		chk("illegal", 18'h1, {17'h0, illegal_reset_ff});
		rd(RCW_CAUSE_ADDR, 8'h02);
		// stop allowed: stop mode halts counting
		wr(RCW_CFG_ADDR, 8'h06);
		mode_pulse(0);
		mode.stop_mode <= 1'b1;
		quiet(8500);
		mode.stop_mode <= 1'b0;
		wr(RCW_CLR_PORT_ADDR, 8'hA5);
		quiet(8000);
		mode_pulse(1);
		wr(RCW_CFG_ADDR, 8'h02);
		timeout_chk();
		// break with test voltage on the reset pin
		wr(RCW_CFG_ADDR, 8'h02);
		vtst_pins.rst_vtst <= 1'b1;
		mode.break_active <= 1'b1;
		quiet(8500);
		vtst_pins.rst_vtst <= 1'b0;
		mode.break_active <= 1'b0;
		wr(RCW_CLR_PORT_ADDR, 8'h5A);
		mode_pulse(3);
		// monitor entered at test voltage, then voltage removed
		vtst_pins.irq_vtst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		mode.monitor_mode <= 1'b1;
		mode_pulse(2);
		quiet(8500);
		vtst_pins.irq_vtst <= 1'b0;
		timeout_chk();
		mode.monitor_mode <= 1'b0;
		// monitor entered on blank vectors stays off until power-on
		wr(RCW_CFG_ADDR, 8'h02);
		mode.monitor_mode <= 1'b1;
		mode_pulse(2);
		mode.monitor_mode <= 1'b0;
		quiet(8500);
		test_done();
	end

	initial begin
		#(98000 * 40);
		n_fail++;
		test_done();
	end

endmodule // testbench
